//--- verilog/spc_top.sv
// serial port timing configuration: registers, clock and frame generation, pin routing
//
// Operation
// - css 0: pcm clock and sync are sources; derived clock and sync driven out
// - css 1: external port clock and frame sync are the sources
// - a rising port frame sync edge starts the serial port frame
// - sync sampled on falling bit clock edge when 0, rising when 1
// - reference clock is source divided by 2, 1.5 or 1; code 11 forbidden
// - port mode selects four, two, one two-way or eight bidirectional ports
// - receive pin select routes logical inputs to upstream pins in modes 1, 2
// - frame pulse control picks generated sync pulse; code 101 reserved
// - clock out rate 0 gives data rate, 1 the source clock (twice rate when divided by 2) in modes 0, 3
// - transmit launched on rising reference edge when 0, falling when 1
// - receive captured on falling reference edge when 0, rising when 1
// - frame length is ten bits, bits per frame minus one, split over registers
// - pcm frame sync sampled with pcm data clock; rising edge starts frame
`timescale 1ns/1ps
`include "spc_map.svh"
module spc_top
  import spc_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // microprocessor port
  input wire logic [`SPC_ADDR_W-1:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  // pcm side timing
  input wire logic PCM_DATA_CLOCK,
  input wire logic PCM_FRAME_SYNC,
  // port clock and frame sync pins
  input wire logic PORT_BIT_CLOCK_IN,
  output logic PORT_BIT_CLOCK_OUT,
  output logic PORT_BIT_CLOCK_OE,
  input wire logic PORT_FRAME_SYNC_IN,
  output logic PORT_FRAME_SYNC_OUT,
  output logic PORT_FRAME_SYNC_OE,
  // strobes to the data path
  output logic PORT_REFERENCE_CLOCK,
  output logic FRAME_START,
  output logic TX_LAUNCH,
  output logic RX_CAPTURE,
  // serial data pins
  input wire logic [3:0] UPSTREAM_PIN_IN,
  output logic [3:0] DOWNSTREAM_OE,
  output logic [3:0] UPSTREAM_OE,
  output logic [7:0] LOGICAL_IN,
  input wire logic [7:0] LOGICAL_OUT,
  output logic [3:0] DOWNSTREAM_PIN_OUT,
  output logic [3:0] UPSTREAM_PIN_OUT,
  // active configuration
  output logic [9:0] FRAME_BIT_COUNT,
  output logic [9:0] BIT_POSITION
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode_one;
    logic [7:0] mode_two;
    logic [7:0] len_low;
    logic [7:0] act_one;
    logic [7:0] act_two;
    logic [7:0] act_len;
    logic [2:0] clk_sync;
    logic [1:0] fs_sync;
    logic fs_samp;
    logic [1:0] pre_cnt;
    logic ref_clk;
    logic [9:0] bit_pos;
    logic [1:0] half;
    logic [7:0] rdata;
    logic bclk_out;
    logic fs_out;
    logic frame_start;
    logic tx_launch;
    logic rx_capture;
    logic [7:0] log_in;
    logic [3:0] dd_out;
    logic [3:0] dd_oe;
    logic [3:0] du_out;
    logic [3:0] du_oe;
  } spc_state_t;

  spc_state_t r;
  spc_state_t next_r;

  // lookup of whether the sync pulse is high at the given bit position for each pulse mode
  function automatic logic [3:0] spc_pulse(input logic [2:0] fc, input logic [9:0] pos,
                                           input logic [9:0] last);
    logic hit;
    hit = 1'b0;
    case (fc)
      3'h0: hit = (pos == 10'h000);
      3'h1: hit = (pos == last);
      3'h2: hit = (pos == last) || (pos == 10'h000);
      3'h3: hit = (pos == 10'h001);
      3'h4: hit = (pos < 10'h002);
      3'h6: hit = (pos < 10'h008);
      3'h7: hit = (pos == 10'h000);
      default: hit = 1'b0;
    endcase
    return {3'h0, hit};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic clock_source_select, sync_rise, clk_rise, clk_fall, samp, fs_now, boundary, clock_out_rate;
  logic [9:0] last;
  logic [1:0] div_lim;
  logic [3:0] pulse;
  spc_mode_t mode;

  always_comb begin
    next_r = r;
    clock_source_select = r.act_one[`SPC_M1_CSS];
    mode = spc_mode_t'(r.act_one[`SPC_M1_MODE_HI:`SPC_M1_MODE_LO]);
    clock_out_rate = r.act_two[`SPC_M2_COC] && !clock_source_select && (mode == SPC_MODE_FOUR || mode == SPC_MODE_EIGHT);
    last = {r.act_two[`SPC_M2_LEN_HI:`SPC_M2_LEN_LO], r.act_len};
    // source clock and frame: r.clk_sync[1] / fs_sync[1] are sync outputs
    next_r.clk_sync = {r.clk_sync[1:0], clock_source_select ? PORT_BIT_CLOCK_IN : PCM_DATA_CLOCK};
    next_r.fs_sync = {r.fs_sync[0], clock_source_select ? PORT_FRAME_SYNC_IN : PCM_FRAME_SYNC};
    clk_rise = r.clk_sync[1] && !r.clk_sync[2];
    clk_fall = !r.clk_sync[1] && r.clk_sync[2];
    samp = r.act_one[`SPC_M1_SYNC] ? clk_rise : clk_fall;
    fs_now = r.fs_sync[1];
    // sync level is kept from one sampling edge to the next, so the rise is seen
    // even when the sync line changes away from the sampling edge
    sync_rise = samp && fs_now && !r.fs_samp;
    if (samp) begin
      next_r.fs_samp = fs_now;
    end
    // prescaler counts source edges; 1.5 approximated by alternating 1 and 2
    div_lim = 2'h0;
    case (spc_div_t'(r.act_one[`SPC_M1_PRE_HI:`SPC_M1_PRE_LO]))
      SPC_DIV_TWO: div_lim = 2'h1;
      SPC_DIV_ONEHALF: div_lim = r.half[0] ? 2'h1 : 2'h0;
      SPC_DIV_ONE: div_lim = 2'h0;
      default: div_lim = 2'h0;
    endcase
    next_r.tx_launch = 1'b0;
    next_r.rx_capture = 1'b0;
    if (clk_rise || clk_fall) begin
      if (r.pre_cnt >= div_lim) begin
        next_r.pre_cnt = 2'h0;
        next_r.ref_clk = !r.ref_clk;
        next_r.half = r.half + 2'h1;
        // launch and capture edges of the reference clock
        next_r.tx_launch = r.act_two[`SPC_M2_TXF] ? r.ref_clk : !r.ref_clk;
        next_r.rx_capture = r.act_two[`SPC_M2_RXR] ? !r.ref_clk : r.ref_clk;
      end else begin
        next_r.pre_cnt = r.pre_cnt + 2'h1;
      end
    end
    // bit position counts one bit per reference period
    boundary = sync_rise || (next_r.tx_launch && r.bit_pos == last);
    next_r.frame_start = boundary;
    if (boundary) begin
      next_r.bit_pos = 10'h000;
      next_r.act_one = r.mode_one;
      next_r.act_two = r.mode_two;
      next_r.act_len = r.len_low;
    end else if (next_r.tx_launch) begin
      next_r.bit_pos = r.bit_pos + 10'h001;
    end
    // output clock at data rate or at the source clock rate, frame pulse by lookup
    pulse = spc_pulse(r.act_two[`SPC_M2_FC_HI:`SPC_M2_FC_LO], r.bit_pos, last);
    next_r.bclk_out = clock_out_rate ? r.clk_sync[1] : r.ref_clk;
    next_r.fs_out = pulse[0];
    // pin routing by port mode
    next_r.dd_out = LOGICAL_OUT[3:0];
    next_r.du_out = 4'h0;
    next_r.du_oe = 4'h0;
    next_r.log_in = {4'h0, UPSTREAM_PIN_IN};
    next_r.dd_oe = 4'hF;
    case (mode)
      SPC_MODE_FOUR: next_r.dd_oe = 4'hF;
      SPC_MODE_TWO: begin
        next_r.dd_oe = 4'h3;
        next_r.log_in = {6'h00,
                         r.act_one[`SPC_M1_PIN_HI] ? UPSTREAM_PIN_IN[3] : UPSTREAM_PIN_IN[1],
                         r.act_one[`SPC_M1_PIN_LO] ? UPSTREAM_PIN_IN[2] : UPSTREAM_PIN_IN[0]};
      end
      SPC_MODE_ONE: begin
        next_r.dd_oe = 4'h1;
        next_r.log_in = {7'h00,
                         r.act_one[`SPC_M1_PIN_LO] ? UPSTREAM_PIN_IN[2] : UPSTREAM_PIN_IN[0]};
      end
      SPC_MODE_EIGHT: begin
        next_r.du_out = LOGICAL_OUT[7:4];
        next_r.du_oe = 4'hF; // bidirectional; data path owns turnaround
        next_r.log_in = {UPSTREAM_PIN_IN, 4'h0};
      end
      default: next_r.dd_oe = 4'h0;
    endcase
    // register writes, read mux; unmapped offsets read zero
    if (WR) begin
      case (ADDR)
        `SPC_OFS_MODE_ONE: next_r.mode_one = WDATA;
        `SPC_OFS_MODE_TWO: next_r.mode_two = WDATA;
        `SPC_OFS_LEN_LOW: next_r.len_low = WDATA;
        default: next_r.rdata = r.rdata;
      endcase
    end
    next_r.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `SPC_OFS_MODE_ONE: next_r.rdata = r.mode_one;
        `SPC_OFS_MODE_TWO: next_r.rdata = r.mode_two;
        `SPC_OFS_LEN_LOW: next_r.rdata = r.len_low;
        default: next_r.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      r <= '0;
      r.mode_one <= `SPC_RST_MODE_ONE;
      r.mode_two <= `SPC_RST_MODE_TWO;
      r.len_low <= `SPC_RST_LEN_LOW;
      r.act_one <= `SPC_RST_MODE_ONE;
      r.act_two <= `SPC_RST_MODE_TWO;
      r.act_len <= `SPC_RST_LEN_LOW;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops; the two pin enables through an inverter
  assign RDATA = r.rdata;
  assign PORT_BIT_CLOCK_OUT = r.bclk_out;
  assign PORT_BIT_CLOCK_OE = !r.act_one[`SPC_M1_CSS];
  assign PORT_FRAME_SYNC_OUT = r.fs_out;
  assign PORT_FRAME_SYNC_OE = !r.act_one[`SPC_M1_CSS];
  assign PORT_REFERENCE_CLOCK = r.ref_clk;
  assign FRAME_START = r.frame_start;
  assign TX_LAUNCH = r.tx_launch;
  assign RX_CAPTURE = r.rx_capture;
  assign LOGICAL_IN = r.log_in;
  assign DOWNSTREAM_PIN_OUT = r.dd_out;
  assign DOWNSTREAM_OE = r.dd_oe;
  assign UPSTREAM_PIN_OUT = r.du_out;
  assign UPSTREAM_OE = r.du_oe;
  assign FRAME_BIT_COUNT = {r.act_two[`SPC_M2_LEN_HI:`SPC_M2_LEN_LO], r.act_len};
  assign BIT_POSITION = r.bit_pos;

endmodule

//--- verilog/spc_map.svh
// register offsets, field positions and reset values of the serial port configuration
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
`define SPC_ADDR_W 4
`define SPC_OFS_MODE_ONE 4'h6
`define SPC_OFS_MODE_TWO 4'h7
`define SPC_OFS_LEN_LOW 4'h8
`define SPC_RST_MODE_ONE 8'h00
`define SPC_RST_MODE_TWO 8'h00
`define SPC_RST_LEN_LOW 8'hFF
`define SPC_M1_CSS 7
`define SPC_M1_SYNC 6
`define SPC_M1_PRE_HI 5
`define SPC_M1_PRE_LO 4
`define SPC_M1_MODE_HI 3
`define SPC_M1_MODE_LO 2
`define SPC_M1_PIN_HI 1
`define SPC_M1_PIN_LO 0
`define SPC_M2_FC_HI 7
`define SPC_M2_FC_LO 5
`define SPC_M2_COC 4
`define SPC_M2_TXF 3
`define SPC_M2_RXR 2
`define SPC_M2_LEN_HI 1
`define SPC_M2_LEN_LO 0
`define SPC_FC_RESERVED 3'h5
`endif

//--- verilog/spc_pkg.sv
// types shared by the serial port configuration block
package spc_pkg;
  typedef enum logic [1:0] {
    SPC_MODE_FOUR = 2'b00,
    SPC_MODE_TWO = 2'b01,
    SPC_MODE_ONE = 2'b10,
    SPC_MODE_EIGHT = 2'b11
  } spc_mode_t;
  typedef enum logic [1:0] {
    SPC_DIV_TWO = 2'b00,
    SPC_DIV_ONEHALF = 2'b01,
    SPC_DIV_ONE = 2'b10,
    SPC_DIV_BAD = 2'b11
  } spc_div_t;
endpackage

//--- tb/spc_asserts.sv
// concurrent checks on the serial port configuration top ports
`timescale 1ns/1ps
module spc_asserts (
  // clock, reset and register port
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [3:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] RDATA,
  // timing outputs
  input wire logic PORT_BIT_CLOCK_OE,
  input wire logic PORT_FRAME_SYNC_OE,
  input wire logic FRAME_START,
  input wire logic TX_LAUNCH,
  input wire logic RX_CAPTURE,
  input wire logic PORT_REFERENCE_CLOCK,
  input wire logic [9:0] FRAME_BIT_COUNT,
  input wire logic [9:0] BIT_POSITION
);
  // -------------------------------
  // checks of the single clock domain
  // -------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_read_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero without a read");
  a_unmapped_read: assert property (RD && !(ADDR inside {4'h6, 4'h7, 4'h8}) |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_len_readback: assert property (WR && ADDR == 4'h8 ##1 RD && !WR && ADDR == 4'h8
    |=> RDATA == $past(WDATA, 2)) else $error("frame length readback differs");
  a_oe_paired: assert property (PORT_BIT_CLOCK_OE == PORT_FRAME_SYNC_OE)
    else $error("clock and sync enables differ");
  a_frame_pulse: assert property (FRAME_START |=> !FRAME_START)
    else $error("frame start longer than one cycle");
  a_tx_pulse: assert property (TX_LAUNCH |=> !TX_LAUNCH)
    else $error("transmit strobe longer than one cycle");
  a_len_at_frame: assert property ($changed(FRAME_BIT_COUNT) |-> FRAME_START || $past(FRAME_START) || !$past(NRST))
    else $error("frame length changed inside a frame");
  a_pos_bound: assert property (BIT_POSITION <= FRAME_BIT_COUNT)
    else $error("bit position beyond frame length");
  a_oe_at_frame: assert property ($changed(PORT_BIT_CLOCK_OE) |-> FRAME_START)
    else $error("clock source changed inside a frame");
  a_tx_on_ref: assert property (TX_LAUNCH |-> $changed(PORT_REFERENCE_CLOCK))
    else $error("transmit strobe off a reference edge");
  a_rx_on_ref: assert property (RX_CAPTURE |-> $changed(PORT_REFERENCE_CLOCK))
    else $error("receive strobe off a reference edge");
  // main scenarios reached
  c_frame: cover property (FRAME_START);
  c_mode_write: cover property (WR && ADDR == 4'h6);
  c_read_data: cover property (RD ##1 RDATA != 8'h00);
  c_ext_source: cover property (!PORT_BIT_CLOCK_OE);
endmodule
bind spc_top spc_asserts chk_u (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR(WR), .RD(RD),
  .WDATA(WDATA), .RDATA(RDATA), .PORT_BIT_CLOCK_OE(PORT_BIT_CLOCK_OE),
  .PORT_FRAME_SYNC_OE(PORT_FRAME_SYNC_OE), .FRAME_START(FRAME_START), .TX_LAUNCH(TX_LAUNCH),
  .RX_CAPTURE(RX_CAPTURE), .PORT_REFERENCE_CLOCK(PORT_REFERENCE_CLOCK),
  .FRAME_BIT_COUNT(FRAME_BIT_COUNT), .BIT_POSITION(BIT_POSITION));

//--- tb/spc_line_model.sv
// line transceiver model: pcm and port timing sources, upstream pin resolution
`timescale 1ns/1ps
module spc_line_model (
  // timing sources
  input wire logic clk,
  output logic bit_clk,
  output logic frame_sync,
  // upstream pins
  input wire logic [3:0] pattern,
  input wire logic [3:0] up_oe,
  input wire logic [3:0] up_out,
  output logic [3:0] up_pins
);
  // ------------------------
  // bit clock and frame sync
  // ------------------------
  logic [7:0] cnt = 8'h00;
  // six system clocks per bit, sixteen bits per frame; runs free like a pcm clock
  always @(posedge clk) begin
    cnt <= (cnt == 8'h5F) ? 8'h00 : cnt + 8'h01;
  end
  assign bit_clk = (cnt % 8'h06) >= 8'h03;
  assign frame_sync = cnt < 8'h06;
  // a pin driven by the block shows its level, else the line card drives it
  assign up_pins = (up_oe & up_out) | (~up_oe & pattern);
endmodule

//--- tb/serial_port_timing_config_tb.sv
// self-checking bench of the serial port configuration block
`timescale 1ns/1ps
module serial_port_timing_config_tb;
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [3:0] ADDR = 4'h0, pattern = 4'h5;
  logic [7:0] WDATA = 8'h00, log_out = 8'h00, RDATA, log_in, rv;
  logic bclk, fsync, bclk_oe, fs_oe, fstart, bclk_out, fs_out;
  logic [3:0] up_pins, up_oe, up_out, dd_oe, dd_out;
  logic [9:0] bit_cnt;
  int miscompares = 0, n_compared = 0;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
  // ----------------
  // clock and blocks
  // ----------------
  always #10 CLK = ~CLK;
  spc_top dut_u (.CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR(WR), .RD(RD), .WDATA(WDATA),
    .RDATA(RDATA), .PCM_DATA_CLOCK(bclk), .PCM_FRAME_SYNC(fsync), .PORT_BIT_CLOCK_IN(bclk),
    .PORT_BIT_CLOCK_OUT(bclk_out), .PORT_BIT_CLOCK_OE(bclk_oe), .PORT_FRAME_SYNC_IN(fsync),
    .PORT_FRAME_SYNC_OUT(fs_out), .PORT_FRAME_SYNC_OE(fs_oe), .PORT_REFERENCE_CLOCK(),
    .FRAME_START(fstart), .TX_LAUNCH(), .RX_CAPTURE(), .UPSTREAM_PIN_IN(up_pins),
    .DOWNSTREAM_OE(dd_oe), .UPSTREAM_OE(up_oe), .LOGICAL_IN(log_in), .LOGICAL_OUT(log_out),
    .DOWNSTREAM_PIN_OUT(dd_out), .UPSTREAM_PIN_OUT(up_out), .FRAME_BIT_COUNT(bit_cnt),
    .BIT_POSITION());
  spc_line_model line_u (.clk(CLK), .bit_clk(bclk), .frame_sync(fsync), .pattern(pattern),
    .up_oe(up_oe), .up_out(up_out), .up_pins(up_pins));
  // register access, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  // write, then read the same offset on the very next edge
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for a fresh frame start, then let the new settings settle
  task automatic wait_frame();
    int i;
    @(posedge CLK) #1;
    for (i = 0; i < 2000 && fstart !== 1'b1; i++) @(posedge CLK) #1;
    if (fstart !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    repeat (3) @(posedge CLK);
    #1;
  endtask
  // downstream drivers per mode: 4, 2, 1 or 4 (bidirectional) active
  function automatic logic [3:0] dd_exp(input int m);
    return (m == 0 || m == 3) ? 4'hF : (m == 1) ? 4'h3 : 4'h1;
  endfunction
  // bits per frame of an 8 kHz frame at a given data rate, minus one
  function automatic logic [9:0] frame_len(input int rate);
    return 10'(rate / 8000 - 1);
  endfunction
  // main sequence
  initial begin
    int m;
    int i;
    logic b0;
    logic [9:0] fl;
    logic [7:0] m1, m2, len;
    logic [1:0] cis;
    void'($urandom(19));
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    rd(4'h6);
    `CHK(rv, 8'h00)
    rd(4'h7);
    `CHK(rv, 8'h00)
    rd(4'h8);
    `CHK(rv, 8'hFF)
    for (m = 0; m < 16; m++) if (m < 6 || m > 8) begin
      wr(m[3:0], 8'hA5);
      rd(m[3:0]);
      `CHK(rv, 8'h00)
    end
    // unmapped writes must not reach the frame length register
    rd(4'h8);
    `CHK(rv, 8'hFF)
    // every port mode, random legal timing settings
    for (m = 0; m < 4; m++) begin
      cis = (m == 1 || m == 2) ? 2'($urandom) : 2'h0;
      m1 = {2'h0, 2'($urandom % 3), m[1:0], cis};
      m2 = {3'($urandom % 5), (m == 0 || m == 3) ? 1'($urandom) : 1'b0, 1'($urandom),
        (m == 3) ? 1'b0 : 1'($urandom), 2'($urandom)};
      len = 8'($urandom);
      // hand corner: frame length derived from a 4096 kbit/s data rate
      fl = frame_len(4096000);
      if (m == 0) begin
        m2[1:0] = fl[9:8];
        len = fl[7:0];
      end
      @(posedge CLK);
      pattern <= 4'($urandom);
      log_out <= 8'($urandom);
      wr(4'h6, m1);
      wr(4'h7, m2);
      wrrd(4'h8, len);
      `CHK(rv, len)
      rd(4'h7);
      `CHK(rv, m2)
      wait_frame();
      `CHK(bit_cnt, {m2[1:0], len})
      `CHK(bclk_oe, 1'b1)
      `CHK(fs_oe, 1'b1)
      `CHK(dd_oe, dd_exp(m))
      `CHK(up_oe, (m == 3) ? 4'hF : 4'h0)
      `CHK(dd_out, log_out[3:0])
      if (m == 0) `CHK(log_in[3:0], pattern)
      if (m == 3) `CHK(log_in[7:4], log_out[7:4])
      if (m == 1 || m == 2) `CHK(log_in[0], cis[0] ? pattern[2] : pattern[0])
      if (m == 1) `CHK(log_in[1], cis[1] ? pattern[3] : pattern[1])
      // derived bit clock must toggle on its own
      b0 = bclk_out;
      for (i = 0; i < 50 && bclk_out === b0; i++) @(posedge CLK) #1;
      `CHK(bclk_out, !b0)
      // every pulse mode but the last-bit one pulses early in each frame
      if (m2[7:5] != 3'h1 && {m2[1:0], len} != 10'h000) begin
        for (i = 0; i < 200 && fs_out !== 1'b1; i++) @(posedge CLK) #1;
        `CHK(fs_out, 1'b1)
      end
    end
    // mid-run reset brings every register back to its reset value
    @(posedge CLK);
    NRST <= 1'b0;
    repeat (2) @(posedge CLK);
    NRST <= 1'b1;
    rd(4'h8);
    `CHK(rv, 8'hFF)
    rd(4'h7);
    `CHK(rv, 8'h00)
    `CHK(bit_cnt, 10'h0FF)
    // external sourcing, either sync edge
    wr(4'h6, {1'b1, 1'($urandom), 6'h00});
    wait_frame();
    `CHK(bclk_oe, 1'b0)
    `CHK(fs_oe, 1'b0)
    complete_run();
  end
endmodule
